/* src/sfc_frame_ctrl.sv */
`timescale 1ns/1ns
// Function
// R1 - the first eight shift-clock rises of a frame clock in the command.
// R2 - the channel address is presented after the fourth rise.
// R3 - sampling runs from the fourth fall to the last fall of the frame.
// R4 - the eleven remaining result bits follow the first one out.
// R5 - the serial output changes only on shift-clock falls; the code also loads the first result bit on the chip select fall.
// R6 - the last fall ends sampling and starts the internal conversion.
// R7 - chip select falling resets the frame; rising disables it.
// R8 - output is off while chip select is high, first bit on its fall.
// R9 - end of conversion is low from the last fall until the result.
// R10 - the host sends the four address bits first, msb first.
module sfc_frame_ctrl
  import sfc_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  input  wire logic        CS_N,
  input  wire logic        IO_CLK,
  input  wire logic        DIN,
  input  wire logic [11:0] CONV_DATA,
  output logic             DOUT_O,
  output logic             DOUT_OE,
  output logic             EOC,
  output logic             SAMPLE,
  output logic [3:0]       ADDR,
  output logic [7:0]       CMD
);

  sfc_conv_if cv ();

  sfc_conv_ctl u_conv (
    .clk       (REF_CLK),
    .srst      (SRST),
    .conv_data (CONV_DATA),
    .cv        (cv)
  );

  // pin synchronisers, stage 2 vs 3 for edges
  logic [2:0] cs_sync_reg;
  logic [2:0] clk_sync_reg;
  logic [1:0] din_sync_reg;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      cs_sync_reg  <= 3'h7;
      clk_sync_reg <= 3'h0;
      din_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg  <= {cs_sync_reg[1:0], CS_N};
      clk_sync_reg <= {clk_sync_reg[1:0], IO_CLK};
      din_sync_reg <= {din_sync_reg[0], DIN};
    end
  end

  logic cs_low;
  logic cs_fall;
  logic clk_rise;
  logic clk_fall;
  logic din_s;

  // edge detection on synchronised pins
  assign cs_low   = ~cs_sync_reg[1];
  assign cs_fall  = ~cs_sync_reg[1] & cs_sync_reg[2];
  assign clk_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign clk_fall = ~clk_sync_reg[1] & clk_sync_reg[2];
  assign din_s    = din_sync_reg[1];

  sfc_frame_t  state_reg, state_next;
  logic [3:0]  rise_cnt_reg, rise_cnt_next;
  logic [3:0]  fall_cnt_reg, fall_cnt_next;
  logic [7:0]  cmd_sh_reg, cmd_sh_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [3:0]  addr_reg, addr_next;
  logic        lsbf_reg, lsbf_next;
  logic [11:0] out_sh_reg, out_sh_next;
  logic        dout_reg, dout_next;
  logic        oe_reg, oe_next;
  logic        sample_reg, sample_next;
  logic        start_reg, start_next;
  logic        eoc_reg, eoc_next;

  // frame sequencing
  always_comb begin
    state_next    = state_reg;
    rise_cnt_next = rise_cnt_reg;
    fall_cnt_next = fall_cnt_reg;
    cmd_sh_next   = cmd_sh_reg;
    cmd_next      = cmd_reg;
    addr_next     = addr_reg;
    lsbf_next     = lsbf_reg;
    out_sh_next   = out_sh_reg;
    dout_next     = dout_reg;
    oe_next       = oe_reg;
    sample_next   = sample_reg;
    start_next    = 1'b0;
    if (!cs_low) begin
      state_next  = SFC_FR_IDLE; // R7
      oe_next     = 1'b0; // R8
      sample_next = 1'b0;
    end else if (cs_fall) begin
      state_next    = SFC_FR_SHIFT; // R7
      rise_cnt_next = SFC_CNT_ZERO;
      fall_cnt_next = SFC_CNT_ZERO;
      out_sh_next   = sfc_order(cv.result, lsbf_reg);
      dout_next     = out_sh_next[SFC_RES_W-1]; // R8
      oe_next       = 1'b1; // R8
    end else if (state_reg == SFC_FR_SHIFT) begin
      if (clk_rise && (rise_cnt_reg < SFC_CMD_BITS)) begin
        cmd_sh_next   = {cmd_sh_reg[SFC_CMD_W-2:0], din_s}; // R1
        rise_cnt_next = rise_cnt_reg + SFC_CNT_ONE;
        if (rise_cnt_next == SFC_ADDR_EDGE) begin
          addr_next = cmd_sh_next[SFC_ADDR_W-1:0]; // R2 R10
        end
        if (rise_cnt_next == SFC_CMD_BITS) begin
          cmd_next  = cmd_sh_next; // R1
          lsbf_next = cmd_sh_next[SFC_LSBF_POS];
        end
      end
      if (clk_fall) begin
        fall_cnt_next = fall_cnt_reg + SFC_CNT_ONE;
        if (fall_cnt_next == SFC_SAMP_EDGE) begin
          sample_next = 1'b1; // R3
        end
        if (fall_cnt_next == SFC_FRAME_BITS) begin
          sample_next = 1'b0; // R3 R6
          start_next  = 1'b1; // R6
          state_next  = SFC_FR_HOLD;
        end else begin
          out_sh_next = {out_sh_reg[SFC_RES_W-2:0], 1'b0}; // R4
          dout_next   = out_sh_reg[SFC_RES_W-2]; // R4 R5
        end
      end
    end
  end

  // end of conversion flag
  always_comb begin
    eoc_next = eoc_reg;
    if (start_reg) begin
      eoc_next = 1'b0; // R9
    end
    if (cv.done) begin
      eoc_next = 1'b1; // R9
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_reg    <= SFC_FR_IDLE;
      rise_cnt_reg <= SFC_CNT_ZERO;
      fall_cnt_reg <= SFC_CNT_ZERO;
      cmd_sh_reg   <= SFC_CMD_RST;
      cmd_reg      <= SFC_CMD_RST;
      addr_reg     <= SFC_ADDR_RST;
      lsbf_reg     <= 1'b0;
      out_sh_reg   <= SFC_RES_RST;
      dout_reg     <= 1'b0;
      oe_reg       <= 1'b0;
      sample_reg   <= 1'b0;
      start_reg    <= 1'b0;
      eoc_reg      <= 1'b1;
    end else begin
      state_reg    <= state_next;
      rise_cnt_reg <= rise_cnt_next;
      fall_cnt_reg <= fall_cnt_next;
      cmd_sh_reg   <= cmd_sh_next;
      cmd_reg      <= cmd_next;
      addr_reg     <= addr_next;
      lsbf_reg     <= lsbf_next;
      out_sh_reg   <= out_sh_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
      sample_reg   <= sample_next;
      start_reg    <= start_next;
      eoc_reg      <= eoc_next;
    end
  end

  // conversion hand-over, one-cycle pulse
  assign cv.start = start_reg;

  // outputs straight from flip-flops
  assign DOUT_O  = dout_reg;
  assign DOUT_OE = oe_reg;
  assign EOC     = eoc_reg;
  assign SAMPLE  = sample_reg;
  assign ADDR    = addr_reg;
  assign CMD     = cmd_reg;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  logic in_frame;
  assign in_frame = cs_low && !cs_fall && (state_reg == SFC_FR_SHIFT);

  sequence s_last_fall;
    in_frame && clk_fall && (fall_cnt_reg == SFC_FRAME_BITS - SFC_CNT_ONE);
  endsequence

  // window closes and start pulses together, end of conversion one later
  sequence s_handover;
    !sample_reg && start_reg ##1 !eoc_reg;
  endsequence

  a_cmd_bit_capture: assert property ( // R1
    in_frame && clk_rise && (rise_cnt_reg < SFC_CMD_BITS) |=>
      cmd_sh_reg == {$past(cmd_sh_reg[6:0]), $past(din_s)})
    else $error("command bit not captured");
  a_addr_after_fourth: assert property ( // R2
    in_frame && clk_rise && (rise_cnt_reg == SFC_ADDR_EDGE - SFC_CNT_ONE)
      |=> addr_reg == {$past(cmd_sh_reg[2:0]), $past(din_s)})
    else $error("address not presented after fourth rise");
  a_sample_start: assert property ( // R3
    in_frame && clk_fall && (fall_cnt_reg == SFC_SAMP_EDGE - SFC_CNT_ONE)
      |=> sample_reg)
    else $error("sampling did not start on fourth fall");
  a_sample_window: assert property ( // R3
    $rose(sample_reg) |-> fall_cnt_reg == SFC_SAMP_EDGE)
    else $error("sampling started outside fourth fall");
  a_result_shift: assert property ( // R4
    in_frame && clk_fall && (fall_cnt_reg < SFC_FRAME_BITS - SFC_CNT_ONE)
      |=> dout_reg == $past(out_sh_reg[10]))
    else $error("result bit not shifted out");
  a_dout_on_fall: assert property ( // R5
    oe_reg && $past(oe_reg) && $changed(dout_reg) |-> $past(clk_fall))
    else $error("serial output changed off a falling edge");
  a_last_fall_handover: assert property ( // R6 R9
    s_last_fall |=> s_handover)
    else $error("last fall did not hand over conversion");
  a_cs_fall_reset: assert property ( // R7 R8
    cs_fall |=> (state_reg == SFC_FR_SHIFT) && oe_reg &&
      (rise_cnt_reg == SFC_CNT_ZERO) && (fall_cnt_reg == SFC_CNT_ZERO) &&
      (dout_reg == out_sh_reg[11]))
    else $error("chip select fall did not restart frame");
  a_oe_off_high: assert property ( // R8
    !cs_low |=> !oe_reg && !sample_reg)
    else $error("output driven with chip select high");
  a_eoc_rise_done: assert property ( // R9
    $rose(eoc_reg) |-> $past(cv.done))
    else $error("end of conversion rose without result");

endmodule

/* src/sfc_pkg.sv */
package sfc_pkg;

  // frame geometry, in shift-clock edges
  localparam logic [3:0] SFC_CMD_BITS   = 4'h8;
  localparam logic [3:0] SFC_ADDR_EDGE  = 4'h4;
  localparam logic [3:0] SFC_SAMP_EDGE  = 4'h4;
  localparam logic [3:0] SFC_FRAME_BITS = 4'hC;
  localparam logic [3:0] SFC_CNT_ZERO   = 4'h0;
  localparam logic [3:0] SFC_CNT_ONE    = 4'h1;

  // result and command layout
  localparam int         SFC_RES_W      = 12;
  localparam int         SFC_CMD_W      = 8;
  localparam int         SFC_ADDR_W     = 4;
  localparam int         SFC_LSBF_POS   = 1;

  // reset values
  localparam logic [11:0] SFC_RES_RST   = 12'h000;
  localparam logic [7:0]  SFC_CMD_RST   = 8'h00;
  localparam logic [3:0]  SFC_ADDR_RST  = 4'h0;

  // conversion time
  localparam int          SFC_CLK_PERIOD_NS = 10;
  localparam int          SFC_CONV_TIME_NS  = 10000;
  localparam int          SFC_CONV_CYCLES   =
    SFC_CONV_TIME_NS / SFC_CLK_PERIOD_NS;
  localparam logic [9:0]  SFC_CONV_LAST     = 10'(SFC_CONV_CYCLES - 1);
  localparam logic [9:0]  SFC_CONV_CNT_ZERO = 10'h000;
  localparam logic [9:0]  SFC_CONV_CNT_ONE  = 10'h001;

  // frame sequencer states
  typedef enum logic [2:0] {
    SFC_FR_IDLE  = 3'h1,
    SFC_FR_SHIFT = 3'h2,
    SFC_FR_HOLD  = 3'h4
  } sfc_frame_t;

  // conversion controller states
  typedef enum logic [1:0] {
    SFC_CV_IDLE = 2'h1,
    SFC_CV_BUSY = 2'h2
  } sfc_conv_t;

  // result in the requested bit order, first bit out at the top
  function automatic logic [11:0] sfc_order(input logic [11:0] d,
                                           input logic        lsbf);
    logic [11:0] r;
    r = d;
    if (lsbf) begin
      for (int i = 0; i < SFC_RES_W; i++) begin
        r[i] = d[SFC_RES_W-1-i];
      end
    end
    return r;
  endfunction

endpackage

/* src/sfc_conv_if.sv */
`timescale 1ns/1ns
interface sfc_conv_if;
  logic        start;
  logic        done;
  logic [11:0] result;
  modport seq (output start, input done, input result);
  modport ctl (input start, output done, output result);
endinterface

/* src/sfc_conv_ctl.sv */
`timescale 1ns/1ns
module sfc_conv_ctl
  import sfc_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [11:0] conv_data,
  sfc_conv_if.ctl         cv
);

  sfc_conv_t   state_reg, state_next;
  logic [9:0]  cnt_reg, cnt_next;
  logic        done_reg, done_next;
  logic [11:0] res_reg, res_next;

  // conversion timing, free of the shift clock
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    done_next  = 1'b0;
    res_next   = res_reg;
    unique case (state_reg)
      SFC_CV_IDLE: begin
        if (cv.start) begin // R6
          state_next = SFC_CV_BUSY;
          cnt_next   = SFC_CONV_CNT_ZERO;
        end
      end
      SFC_CV_BUSY: begin
        cnt_next = cnt_reg + SFC_CONV_CNT_ONE;
        if (cnt_reg == SFC_CONV_LAST) begin // R9
          state_next = SFC_CV_IDLE;
          done_next  = 1'b1;
          res_next   = conv_data;
        end
      end
      default: state_next = SFC_CV_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SFC_CV_IDLE;
      cnt_reg   <= SFC_CONV_CNT_ZERO;
      done_reg  <= 1'b0;
      res_reg   <= SFC_RES_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      done_reg  <= done_next;
      res_reg   <= res_next;
    end
  end

  assign cv.done   = done_reg;
  assign cv.result = res_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_conv_done_time: assert property ( // R9
    $rose(done_reg) |-> $past(cnt_reg) == SFC_CONV_LAST)
    else $error("conversion finished at the wrong count");
  a_conv_takes_start: assert property ( // R6
    (state_reg == SFC_CV_IDLE) && cv.start |=>
      (state_reg == SFC_CV_BUSY) && (cnt_reg == SFC_CONV_CNT_ZERO))
    else $error("conversion start not taken");

endmodule

/* testbench/sfc_host_model.sv */
`timescale 1ns/1ns
module sfc_host_model (
  output logic      cs_n,
  output logic      io_clk,
  output logic      din,
  input  wire logic dout,
  input  wire logic sample
);
  logic [11:0] res;
  logic [11:0] samp;
  int          n_glitch;

  // link idle: deselected, shift clock parked low
  initial begin
    cs_n     = 1'b1;
    io_clk   = 1'b0;
    din      = 1'b0;
    n_glitch = 0;
  end

  // frame of n pulses, 125 ns period, bits taken just before each rise
  task automatic frame(input logic [7:0] cmd, input int n);
    logic d;
    samp = 12'h000;
    cs_n = 1'b0;
    #150;
    for (int i = 0; i < n; i++) begin
      din = (i < 8) ? cmd[7-i] : 1'b0;
      #8;
      res[11-i] = dout;
      d         = dout;
      io_clk    = 1'b1;
      #62;
      if (dout !== d) n_glitch++;
      io_clk  = 1'b0;
      #55;
      samp[i] = sample;
    end
    cs_n = 1'b1;
    din  = 1'b0;
  endtask
endmodule

/* testbench/sfc_frame_ctrl_bench.sv */
`timescale 1ns/1ns
module sfc_frame_ctrl_bench;
  import sfc_pkg::*;
  logic        ref_clk;
  logic        srst;
  logic [11:0] conv_data;
  logic        cs_n;
  logic        io_clk;
  logic        din;
  logic        dout_o;
  logic        dout_oe;
  logic        eoc;
  logic        sample;
  logic [3:0]  addr;
  logic [7:0]  cmd;
  logic        dout_line;
  int          n_fail;
  int          num_checks;

  sfc_frame_ctrl uut (
    .REF_CLK   (ref_clk),
    .SRST      (srst),
    .CS_N      (cs_n),
    .IO_CLK    (io_clk),
    .DIN       (din),
    .CONV_DATA (conv_data),
    .DOUT_O    (dout_o),
    .DOUT_OE   (dout_oe),
    .EOC       (eoc),
    .SAMPLE    (sample),
    .ADDR      (addr),
    .CMD       (cmd)
  );

  // released line shows the inverse of the last bit driven
  assign dout_line = dout_oe ? dout_o : ~dout_o;

  sfc_host_model host (
    .cs_n   (cs_n),
    .io_clk (io_clk),
    .din    (din),
    .dout   (dout_line),
    .sample (sample)
  );

  // 100 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    num_checks++;
    if (e !== g) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // bounded wait for the conversion to finish
  task automatic wait_eoc();
    int k;
    k = 0;
    while (eoc !== 1'b1 && k < 1100) begin
      cyc(1);
      k++;
    end
    if (eoc !== 1'b1) begin
      n_fail++;
      $display("unexpected eoc timeout: expected 1 seen %b", eoc);
      close_out();
    end
  endtask

  task automatic t_reset();
    chk("oe", 12'h000, {11'h000, dout_oe});
    chk("eoc", 12'h001, {11'h000, eoc});
    chk("sample", 12'h000, {11'h000, sample});
    chk("cmd", 12'h000, {4'h0, cmd});
  endtask

  // full twelve-pulse frame: command, window, old result, conversion
  task automatic t_frame(input logic [7:0] c, input logic [11:0] r);
    host.frame(c, 12);
    chk("result", r, host.res);
    chk("window", 12'h7F8, host.samp);
    chk("glitch", 12'h000, 12'(host.n_glitch));
    chk("addr", {8'h00, c[7:4]}, {8'h00, addr});
    chk("cmd", {4'h0, c}, {4'h0, cmd});
    cyc(8);
    chk("oe off", 12'h000, {11'h000, dout_oe});
    chk("eoc low", 12'h000, {11'h000, eoc});
    chk("sample off", 12'h000, {11'h000, sample});
    wait_eoc();
  endtask

  // deselect after six pulses: window cut, no conversion
  task automatic t_abort();
    host.frame(8'hC0, 6);
    chk("abort window", 12'h038, host.samp);
    cyc(20);
    chk("abort sample", 12'h000, {11'h000, sample});
    chk("abort eoc", 12'h001, {11'h000, eoc});
    chk("abort oe", 12'h000, {11'h000, dout_oe});
  endtask

  // oe is driven while a frame is selected
  task automatic t_oe();
    fork
      host.frame(8'h00, 12);
      begin
        #100;
        chk("oe on", 12'h001, {11'h000, dout_oe});
      end
    join
    wait_eoc();
  endtask

  initial begin
    n_fail     = 0;
    num_checks = 0;
    srst       = 1'b1;
    conv_data  = 12'hB5C;
    cyc(4);
    srst = 1'b0;
    cyc(2);
    t_reset();
    t_frame(8'hA4, 12'h000);
    t_frame(8'h36, 12'hB5C);
    conv_data = 12'h3A1;
    // lsb first after a command with bit 1 set: reverse of B5C
    t_frame(8'h50, 12'h3AD);
    t_abort();
    t_frame(8'h1C, 12'h3A1);
    t_oe();
    close_out();
  end
endmodule
